// ---- hdl/twu_defs.svh ----
// Constants for the timed write unlock gate: offsets, keys, resets, timing
`ifndef TWU_DEFS_SVH
`define TWU_DEFS_SVH

// Register indices; byte address is four times the index
`define TWU_IDX_KEY        8'hc7
`define TWU_IDX_WDCTRL     8'hc8
`define TWU_IDX_STATUS     8'hc9

// Key bytes, in the order they must arrive
`define TWU_KEY_FIRST      8'haa
`define TWU_KEY_SECOND     8'h55

// Reset values
`define TWU_WDCTRL_RESET   8'h00

// Status field positions
`define TWU_STAT_OPEN_BIT  0
`define TWU_STAT_WAIT_BIT  1

// Timing: clocks per machine cycle and the two windows in machine cycles
`define TWU_MC_CLKS        4
`define TWU_KEY_WAIT_MC    3
`define TWU_WINDOW_MC      3

`endif

// ---- hdl/twu_pkg.sv ----
// Types shared by the timed write unlock gate
package twu_pkg;

  // Gate states
  typedef enum logic [1:0] {
    TWU_IDLE,
    TWU_WAIT,
    TWU_OPEN
  } twu_state_t;

  // One committed write to the key register
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } twu_key_wr_t;

  // Gate status seen by the register file
  typedef struct packed {
    logic key_wait;
    logic win_open;
  } twu_gate_stat_t;

endpackage

// ---- hdl/twu_key_gate.sv ----
// Key sequence checker and write window timer
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "twu_defs.svh"

module twu_key_gate
  import twu_pkg::*;
(
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // Committed key write
  input  wire twu_key_wr_t    key_wr,
  // Gate status
  output twu_gate_stat_t      gate_stat
);

  localparam int WAIT_CLKS = `TWU_KEY_WAIT_MC * `TWU_MC_CLKS;
  localparam int WIN_CLKS  = `TWU_WINDOW_MC * `TWU_MC_CLKS;

  twu_state_t state_reg;
  twu_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;

  // Key decode
  wire logic key_first  = key_wr.valid && (key_wr.data == `TWU_KEY_FIRST);
  wire logic key_second = key_wr.valid && (key_wr.data == `TWU_KEY_SECOND);
  wire logic key_other  = key_wr.valid && !key_first && !key_second;
  wire logic cnt_done   = (cnt_reg == 4'h0);

  // Sequence and timer; a first key always restarts the wait, even mid-window
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_done ? 4'h0 : cnt_reg - 4'h1;
    case (state_reg)
      TWU_IDLE: begin
        if (key_first) begin
          state_next = TWU_WAIT;
          cnt_next   = 4'(WAIT_CLKS - 1);
        end
      end
      TWU_WAIT: begin
        if (key_first) begin
          cnt_next = 4'(WAIT_CLKS - 1);
        end else if (key_second) begin
          state_next = TWU_OPEN;
          cnt_next   = 4'(WIN_CLKS - 1);
        end else if (key_other || cnt_done) begin
          state_next = TWU_IDLE;
        end
      end
      TWU_OPEN: begin
        if (key_first) begin
          state_next = TWU_WAIT;
          cnt_next   = 4'(WAIT_CLKS - 1);
        end else if (cnt_done) begin
          state_next = TWU_IDLE;
        end
      end
      default: state_next = TWU_IDLE;
    endcase
  end

  // State flops; reset leaves the gate locked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= TWU_IDLE;
      cnt_reg   <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign gate_stat.win_open = (state_reg == TWU_OPEN);
  assign gate_stat.key_wait = (state_reg == TWU_WAIT);

  // Helper ages for bounded-length checks
  logic [4:0] open_age;
  logic [4:0] wait_age;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_age <= 5'h00;
      wait_age <= 5'h00;
    end else begin
      open_age <= (state_next == TWU_OPEN) ? open_age + 5'h01 : 5'h00;
      wait_age <= (state_next == TWU_WAIT && !key_first) ? wait_age + 5'h01 : 5'h00;
    end
  end

  a_second_key_opens: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == TWU_WAIT && key_second) |=> gate_stat.win_open)
    else $error("second key in time did not open the window");

  a_window_length: assert property (@(posedge pclk) disable iff (!presetn)
    open_age <= 5'd12)
    else $error("write window stayed open too long");

  a_window_full: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(gate_stat.win_open) && !key_first) ##1 (!key_first)[*8]
      |-> gate_stat.win_open)
    else $error("write window closed early");

  a_wait_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    wait_age <= 5'd11)
    else $error("key wait lasted too long");

  a_late_key_fails: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == TWU_IDLE && key_second) |=> !gate_stat.win_open)
    else $error("late second key opened the window");

  a_wrong_key_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == TWU_WAIT && key_other) |=> (state_reg == TWU_IDLE))
    else $error("wrong key did not abandon the wait");

  c_open_window: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(gate_stat.win_open));
  c_wait_timeout: cover property (@(posedge pclk) disable iff (!presetn)
    (state_reg == TWU_WAIT && cnt_done && !key_wr.valid));

endmodule

// ---- hdl/twu_top.sv ----
// APB slave holding the timed write unlock gate and its protected register
`timescale 1ns/1ps
`include "twu_defs.svh"

module twu_top
  import twu_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Protected watchdog control bits to the watchdog
  output logic [7:0]       watchdog_ctrl
);

  logic [31:0]    prdata_reg;
  logic           pready_reg;
  logic           pslverr_reg;
  logic [7:0]     wdctrl_reg;
  twu_key_wr_t    key_wr;
  twu_gate_stat_t gate_stat;

  // Address decode on word index; low two address bits are ignored
  wire logic [9:0] word_idx  = paddr[11:2];
  wire logic       hit_key   = (word_idx == {2'b00, `TWU_IDX_KEY});
  wire logic       hit_wd    = (word_idx == {2'b00, `TWU_IDX_WDCTRL});
  wire logic       hit_stat  = (word_idx == {2'b00, `TWU_IDX_STATUS});
  wire logic       hit_any   = hit_key || hit_wd || hit_stat;
  // Stat is read only and key write only; the wrong direction is an error
  wire logic       bad_dir   = (hit_stat && pwrite) || (hit_key && !pwrite);
  wire logic       access    = psel && penable;
  wire logic       commit    = access && pready_reg;
  wire logic       wr_ok     = commit && pwrite && !pslverr_reg;
  wire logic       pready_next  = access && !pready_reg;
  wire logic       pslverr_next = pready_next && (!hit_any || bad_dir);

  // Read mux; key register reads as zero
  wire logic [31:0] rd_mux =
    hit_wd   ? {24'h000000, wdctrl_reg} :
    hit_stat ? {30'h00000000, gate_stat.key_wait, gate_stat.win_open} :
               32'h00000000;
  wire logic [31:0] prdata_next = (pready_next && !pwrite) ? rd_mux : 32'h00000000;

  // Key writes go to the gate only at the completing edge
  assign key_wr.valid = wr_ok && hit_key;
  assign key_wr.data  = pwdata[7:0];

  // Protected write is taken only inside the open window
  wire logic       wd_take     = wr_ok && hit_wd && gate_stat.win_open;
  wire logic [7:0] wdctrl_next = wd_take ? pwdata[7:0] : wdctrl_reg;

  twu_key_gate u_gate (
    .pclk      (pclk),
    .presetn   (presetn),
    .key_wr    (key_wr),
    .gate_stat (gate_stat)
  );

  // One wait state so every answer comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // Protected register; reset value holds until a window write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdctrl_reg <= `TWU_WDCTRL_RESET;
    end else begin
      wdctrl_reg <= wdctrl_next;
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign watchdog_ctrl = wdctrl_reg;

  wire logic wd_commit = commit && pwrite && hit_wd;

  a_closed_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (wd_commit && !gate_stat.win_open) |=> $stable(wdctrl_reg))
    else $error("protected write landed while window closed");

  a_open_write_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wd_commit && gate_stat.win_open) |=> (wdctrl_reg == $past(pwdata[7:0])))
    else $error("protected write in window was lost");

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready_reg) |=> pready_reg)
    else $error("APB answer not given after one wait state");

  c_protected_update: cover property (@(posedge pclk) disable iff (!presetn)
    wd_commit && gate_stat.win_open);
  c_protected_drop: cover property (@(posedge pclk) disable iff (!presetn)
    wd_commit && !gate_stat.win_open);

endmodule

// ---- tb/twu_tb.sv ----
// Self-checking bench for the timed write unlock gate over APB
`timescale 1ns/1ps
`include "twu_defs.svh"

module tb;
  import twu_pkg::*;

  localparam logic [11:0] A_KEY = 12'({`TWU_IDX_KEY, 2'b00});
  localparam logic [11:0] A_WD  = 12'({`TWU_IDX_WDCTRL, 2'b00});
  localparam logic [11:0] A_ST  = 12'({`TWU_IDX_STATUS, 2'b00});
  localparam logic [31:0] S_OPEN = 32'h1 << `TWU_STAT_OPEN_BIT;
  localparam logic [31:0] S_WAIT = 32'h1 << `TWU_STAT_WAIT_BIT;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  watchdog_ctrl;
  logic [31:0] rdat;
  logic        rerr;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;

  twu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_ctrl(watchdog_ctrl));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Key pair, idle gaps, then a protected write; gaps add to a 4-clock spacing
  task automatic seq(input logic [7:0] k1, input logic [7:0] k2, input int kg,
    input int wg, input logic [7:0] v, input logic [7:0] exp);
    apb(1'b1, A_KEY, {24'h0, k1});
    repeat (kg) @(posedge pclk);
    apb(1'b1, A_KEY, {24'h0, k2});
    repeat (wg) @(posedge pclk);
    apb(1'b1, A_WD, {24'h0, v});
    chk({24'h0, watchdog_ctrl}, {24'h0, exp});
  endtask

  task automatic t_reset();
    chk({24'h0, watchdog_ctrl}, {24'h0, `TWU_WDCTRL_RESET});
    apb(1'b0, A_WD, 32'h0);
    chk({31'h0, rerr}, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, A_WD, 32'h5a);
    chk({24'h0, watchdog_ctrl}, 32'h0);
    $display("test reset and locked done");
  endtask

  task automatic t_gate();
    seq(8'haa, 8'h55, 0, 0, 8'ha5, 8'ha5);
    seq(8'haa, 8'h55, 8, 0, 8'h3c, 8'h3c);
    seq(8'haa, 8'h55, 0, 8, 8'hc3, 8'hc3);
    seq(8'haa, 8'h55, 0, 9, 8'h11, 8'hc3);
    seq(8'haa, 8'h55, 12, 0, 8'h22, 8'hc3);
    seq(8'haa, 8'h12, 0, 0, 8'h33, 8'hc3);
    seq(8'h55, 8'haa, 0, 0, 8'h44, 8'hc3);
    apb(1'b1, A_KEY, 32'haa);
    seq(8'haa, 8'h55, 0, 0, 8'h66, 8'h66);
    $display("test key sequences done");
  endtask

  // Two writes land in one window; after it closes a lone write is dropped
  task automatic t_multi();
    seq(8'haa, 8'h55, 0, 0, 8'h01, 8'h01);
    apb(1'b1, A_WD, 32'h02);
    chk({24'h0, watchdog_ctrl}, 32'h02);
    apb(1'b0, A_WD, 32'h0);
    chk(rdat, 32'h02);
    repeat (16) @(posedge pclk);
    apb(1'b1, A_WD, 32'h03);
    chk({24'h0, watchdog_ctrl}, 32'h02);
    $display("test window reuse done");
  endtask

  task automatic t_status();
    apb(1'b1, A_KEY, 32'haa);
    apb(1'b0, A_ST, 32'h0);
    chk(rdat, S_WAIT);
    apb(1'b1, A_KEY, 32'h55);
    apb(1'b0, A_ST, 32'h0);
    chk(rdat, S_OPEN);
    repeat (16) @(posedge pclk);
    apb(1'b0, A_ST, 32'h0);
    chk(rdat, 32'h0);
    $display("test status done");
  endtask

  // Refused transfers: key read, status write, unmapped address
  task automatic t_errors();
    apb(1'b0, A_KEY, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, A_ST, 32'hff);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    chk({24'h0, watchdog_ctrl}, 32'h02);
    $display("test errors done");
  endtask

  // Reset in mid-run with the window open must relock the gate
  task automatic t_midreset();
    seq(8'haa, 8'h55, 0, 0, 8'h77, 8'h77);
    apb(1'b1, A_KEY, 32'haa);
    apb(1'b1, A_KEY, 32'h55);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({24'h0, watchdog_ctrl}, {24'h0, `TWU_WDCTRL_RESET});
    apb(1'b0, A_ST, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, A_WD, 32'h5a);
    chk({24'h0, watchdog_ctrl}, {24'h0, `TWU_WDCTRL_RESET});
    $display("test mid-run reset done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_gate();
    t_multi();
    t_status();
    t_errors();
    t_midreset();
    end_of_test();
  end
endmodule
